// ==== include/mpa_cfg.svh ====
// register map, reset values and timing for the motor pwm block
`ifndef MPA_CFG_SVH
`define MPA_CFG_SVH
`define MPA_CLK_HZ 50000000
`define MPA_CLK_MHZ 50
`define MPA_PWM_HZ 10000
`define MPA_MOD_RST (`MPA_CLK_HZ / `MPA_PWM_HZ)
`define MPA_DT_NS_RST 500
`define MPA_RATIO_RST 4'h1
`define MPA_A_CTRL 8'h00
`define MPA_A_MOD 8'h04
`define MPA_A_DT 8'h08
`define MPA_A_TRIG 8'h0C
`define MPA_A_DUTY0 8'h10
`define MPA_A_STAT 8'h1C
`define MPA_A_MASK 8'h20
`define MPA_A_RES0 8'h24
`define MPA_A_STATE 8'h34
`define MPA_C_RUN 0
`define MPA_C_RATIO_LO 4
`define MPA_C_XOFF 8
`define MPA_S_DONE 0
`define MPA_S_FLT 1
`define MPA_S_RLD 2
`define MPA_NCH 4
`endif

// ==== include/mpa_pkg.sv ====
// types shared by the motor pwm block
package mpa_pkg;
  typedef struct packed {
    logic [2:0] top;
    logic [2:0] bot;
  } mpa_gate_t;
  typedef enum logic [2:0] {
    ADC_IDLE = 3'b001,
    ADC_GO = 3'b010,
    ADC_WAIT = 3'b100
  } mpa_adc_st_t;
endpackage

// ==== verilog/mpa_top.sv ====
// three-phase centre-aligned pwm with dead time, fault and conversion sync
// Notes on behaviour
// - six gate outputs, top and bottom for each of three submodules
// - master reload issued only every nth period end, n programmable
// - submodules one and two count on the master submodule's tick
// - counters of submodules one and two reinit on master reload
// - after reload, trigger fires when master count equals trigger compare value
// - trigger compare point shifted by half the dead time
// - fault shuts all six outputs, cleared automatically by hardware
// - outputs come back only at first period reload after fault low
// - period counts from minus half modulo to half modulo minus one
// - programmable dead time between top and bottom of each phase
// - triggered twelve-bit conversions of three currents and bus voltage
// - crossbar routes master trigger to converter start
// - conversion sequence done raises the conversion-done interrupt
// - dead time given in nanoseconds, turned into clock cycles
// - fast-loop trigger every first, second, third or nth reload
`timescale 1ns/1ps
`include "mpa_cfg.svh"
`default_nettype none
module mpa_top
  import mpa_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // gate driver
  input wire logic fault_in,
  output mpa_gate_t gate,
  // converter
  output logic adc_start,
  output logic [1:0] adc_chan,
  input wire logic adc_eoc,
  input wire logic [11:0] adc_data,
  // interrupt
  output logic irq
);

  function automatic logic signed [15:0] half(input logic [15:0] v);
    return signed'({1'b0, v[15:1]});
  endfunction

  function automatic logic [15:0] ns_to_cyc(input logic [15:0] ns);
    logic [31:0] p;
    p = 32'({16'h0000, ns} * `MPA_CLK_MHZ + 999) / 32'd1000;
    return 16'(p);
  endfunction

  // registers
  logic [31:0] ctrl_ff;
  logic [15:0] mod_ff;
  logic [15:0] dt_ns_ff;
  logic signed [15:0] trig_ff;
  logic [15:0] duty_ff [3];
  logic [15:0] duty_act_ff [3];
  logic [2:0] stat_ff;
  logic [2:0] mask_ff;
  logic [11:0] res_ff [`MPA_NCH];
  logic [31:0] rdata_ff;
  logic irq_ff;
  // pin synchronisers
  logic flt_m_ff, flt_s_ff;
  logic eoc_m_ff, eoc_s_ff, eoc_d_ff;
  logic [11:0] dat_m_ff, dat_s_ff;
  // counters and gating
  logic signed [15:0] sc_ff [3];
  logic [3:0] rcnt_ff;
  logic arm_ff;
  logic flt_ff;
  logic [2:0] cur_ff;
  logic [15:0] dtc_ff [3];
  mpa_gate_t gate_ff;
  // conversion sequencer
  mpa_adc_st_t adc_st_ff;
  logic [1:0] chan_ff;
  logic start_ff;

  // decode
  wire run = ctrl_ff[`MPA_C_RUN];
  wire [3:0] ratio = ctrl_ff[`MPA_C_RATIO_LO +: 4];
  wire xoff = ctrl_ff[`MPA_C_XOFF];
  wire wr_ctrl = wr && addr == `MPA_A_CTRL;
  wire wr_mod = wr && addr == `MPA_A_MOD;
  wire wr_dt = wr && addr == `MPA_A_DT;
  wire wr_trig = wr && addr == `MPA_A_TRIG;
  wire wr_mask = wr && addr == `MPA_A_MASK;
  wire rd_stat = rd && addr == `MPA_A_STAT;

  // period limits
  wire signed [15:0] init_v = -half(mod_ff);
  wire signed [15:0] end_v = half(mod_ff) - 16'sh0001;
  wire [15:0] dt_cyc = ns_to_cyc(dt_ns_ff);
  // master tick shared by all submodules, no own prescalers
  wire sm_tick = run;
  wire period_end = sm_tick && sc_ff[0] == end_v;
  // zero ratio treated as one so reload never stops
  wire [3:0] ratio_m1 = (ratio == 4'h0) ? 4'h0 : ratio - 4'h1;
  // at or past the ratio, so lowering it while running cannot stall reload for a full wrap
  wire master_rl = period_end && rcnt_ff >= ratio_m1;
  wire signed [15:0] trig_eff = trig_ff + half(dt_cyc);
  wire pwm_trig = sm_tick && arm_ff && sc_ff[0] == trig_eff;
  wire adc_trig = pwm_trig && !xoff;
  wire kill = flt_ff || flt_s_ff || !run;
  wire eoc_rise = eoc_s_ff && !eoc_d_ff;
  wire conv_done = adc_st_ff == ADC_WAIT && eoc_rise && chan_ff == 2'(`MPA_NCH - 1);
  wire flt_event = flt_s_ff && !flt_ff;
  wire [2:0] ev = {master_rl, flt_event, conv_done};

  logic [2:0] raw;
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      raw[i] = sc_ff[i] >= -half(duty_act_ff[i]) && sc_ff[i] < half(duty_act_ff[i]);
    end
  end

  // read mux
  wire [3:0] ridx = 4'(addr[7:2]);
  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h00000000;
    unique case (addr)
      `MPA_A_CTRL: rmux = ctrl_ff;
      `MPA_A_MOD: rmux = {16'h0000, mod_ff};
      `MPA_A_DT: rmux = {16'h0000, dt_ns_ff};
      `MPA_A_TRIG: rmux = {16'h0000, trig_ff};
      `MPA_A_DUTY0, 8'h14, 8'h18: rmux = {16'h0000, duty_ff[2'(ridx - 4'h4)]};
      `MPA_A_STAT: rmux = {29'h00000000, stat_ff};
      `MPA_A_MASK: rmux = {29'h00000000, mask_ff};
      `MPA_A_RES0, 8'h28, 8'h2C, 8'h30: rmux = {20'h00000, res_ff[2'(ridx - 4'h9)]};
      `MPA_A_STATE: rmux = {28'h0000000, adc_st_ff != ADC_IDLE, flt_s_ff, flt_ff, run};
      default: rmux = 32'h00000000;
    endcase
  end

  // bus registers and interrupt
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl_ff <= {23'h000000, 1'b0, `MPA_RATIO_RST, 4'h0};
      mod_ff <= 16'(`MPA_MOD_RST);
      dt_ns_ff <= 16'(`MPA_DT_NS_RST);
      trig_ff <= 16'sh0000;
      mask_ff <= 3'h0;
      stat_ff <= 3'h0;
      rdata_ff <= 32'h00000000;
      irq_ff <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
        duty_ff[i] <= 16'h0000;
      end
    end
    else
    begin
      if (wr_ctrl) ctrl_ff <= wdata;
      if (wr_mod) mod_ff <= wdata[15:0];
      if (wr_dt) dt_ns_ff <= wdata[15:0];
      if (wr_trig) trig_ff <= wdata[15:0];
      if (wr_mask) mask_ff <= wdata[2:0];
      for (int i = 0; i < 3; i++)
      begin
        if (wr && addr == 8'(`MPA_A_DUTY0 + 4 * i)) duty_ff[i] <= wdata[15:0];
      end
      // an event in the clearing read survives it
      stat_ff <= (rd_stat ? 3'h0 : stat_ff) | ev;
      rdata_ff <= rd ? rmux : 32'h00000000;
      irq_ff <= |(((rd_stat ? 3'h0 : stat_ff) | ev) & mask_ff);
    end
  end

  // pin synchronisers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      {flt_m_ff, flt_s_ff, eoc_m_ff, eoc_s_ff, eoc_d_ff} <= 5'h00;
      dat_m_ff <= 12'h000;
      dat_s_ff <= 12'h000;
    end
    else
    begin
      {flt_s_ff, flt_m_ff} <= {flt_m_ff, fault_in};
      {eoc_s_ff, eoc_m_ff} <= {eoc_m_ff, adc_eoc};
      eoc_d_ff <= eoc_s_ff;
      dat_m_ff <= adc_data;
      dat_s_ff <= dat_m_ff;
    end
  end

  // counters, reload, trigger arm, fault latch
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rcnt_ff <= 4'h0;
      arm_ff <= 1'b0;
      flt_ff <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
        sc_ff[i] <= 16'sh0000;
        duty_act_ff[i] <= 16'h0000;
      end
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (!sm_tick || master_rl || sc_ff[i] == end_v) sc_ff[i] <= init_v;
        else sc_ff[i] <= sc_ff[i] + 16'sh0001;
        // duty takes effect at the master reload or directly while stopped, all phases at once
        if (!run || master_rl) duty_act_ff[i] <= duty_ff[i];
      end
      if (!sm_tick || master_rl) rcnt_ff <= 4'h0;
      else if (period_end) rcnt_ff <= rcnt_ff + 4'h1;
      if (master_rl) arm_ff <= 1'b1;
      else if (pwm_trig) arm_ff <= 1'b0;
      if (flt_s_ff) flt_ff <= 1'b1;
      else if (period_end) flt_ff <= 1'b0;
    end
  end

  // dead time and gate outputs
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cur_ff <= 3'h0;
      gate_ff <= '0;
      for (int i = 0; i < 3; i++)
      begin
        dtc_ff[i] <= 16'h0000;
      end
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (raw[i] != cur_ff[i])
        begin
          cur_ff[i] <= raw[i];
          dtc_ff[i] <= dt_cyc;
        end
        else if (dtc_ff[i] != 16'h0000)
        begin
          dtc_ff[i] <= dtc_ff[i] - 16'h0001;
        end
        // both off on any edge and for the whole dead time
        gate_ff.top[i] <= !kill && raw[i] == cur_ff[i] && cur_ff[i] && dtc_ff[i] <= 16'h0001;
        gate_ff.bot[i] <= !kill && raw[i] == cur_ff[i] && !cur_ff[i] && dtc_ff[i] <= 16'h0001;
      end
    end
  end

  // conversion sequencer: three currents then bus voltage
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      adc_st_ff <= ADC_IDLE;
      chan_ff <= 2'h0;
      start_ff <= 1'b0;
      for (int i = 0; i < `MPA_NCH; i++)
      begin
        res_ff[i] <= 12'h000;
      end
    end
    else
    begin
      start_ff <= 1'b0;
      unique case (adc_st_ff)
        ADC_IDLE:
        begin
          // trigger while busy is dropped, next one comes a loop later
          if (adc_trig)
          begin
            chan_ff <= 2'h0;
            adc_st_ff <= ADC_GO;
          end
        end
        ADC_GO:
        begin
          start_ff <= 1'b1;
          adc_st_ff <= ADC_WAIT;
        end
        ADC_WAIT:
        begin
          if (eoc_rise)
          begin
            res_ff[chan_ff] <= dat_s_ff;
            chan_ff <= chan_ff + 2'h1;
            adc_st_ff <= conv_done ? ADC_IDLE : ADC_GO;
          end
        end
        default: adc_st_ff <= ADC_IDLE;
      endcase
    end
  end

  assign rdata = rdata_ff;
  assign gate = gate_ff;
  assign adc_start = start_ff;
  assign adc_chan = chan_ff;
  assign irq = irq_ff;

endmodule
`default_nettype wire

// ==== dv/mpa_top_asserts.sv ====
// port-level assertions for the motor pwm block
`timescale 1ns/1ps
`default_nettype none
module mpa_top_asserts
  import mpa_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // watched ports
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic fault_in,
  input wire mpa_gate_t gate,
  input wire logic adc_start,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_NO_SHOOT: assert property ((gate.top & gate.bot) == 3'h0)
    else $error("top and bottom on together");
  AST_DT_TOP: assert property ($rose(gate.top[0]) |-> $past(!gate.bot[0], 2))
    else $error("top rose without dead time");
  AST_DT_BOT: assert property ($rose(gate.bot[1]) |-> $past(!gate.top[1], 2))
    else $error("bottom rose without dead time");
  AST_FLT_OFF: assert property (fault_in [*4] |-> gate == 6'h00)
    else $error("gates on during fault");
  AST_FLT_HOLD: assert property (fault_in [*4] ##1 !fault_in |-> (gate == 6'h00) [*2])
    else $error("gates back before reload");
  AST_START_PULSE: assert property (adc_start |=> !adc_start [*3])
    else $error("start pulse too long");
  AST_RD_IDLE: assert property (!rd |=> rdata == 32'h0)
    else $error("read data without read");
  AST_REL_QUIET: assert property ($rose(rstn) |-> gate == 6'h00 && !adc_start && !irq)
    else $error("outputs active at reset release");
endmodule
bind mpa_top mpa_top_asserts chk_i (.clk(clk), .rstn(rstn), .rd(rd), .rdata(rdata),
  .fault_in(fault_in), .gate(gate), .adc_start(adc_start), .irq(irq));
`default_nettype wire

// ==== dv/mpa_drv_model.sv ====
// gate driver with fault line and converter front end
`timescale 1ns/1ps
`default_nettype none
module mpa_drv_model
  import mpa_pkg::*;
#(
  parameter logic [3:0] LAT = 4'h6
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bridge side
  input wire mpa_gate_t gate,
  input wire logic flt_req,
  output logic fault_in,
  // converter side
  input wire logic adc_start,
  input wire logic [1:0] adc_chan,
  output logic adc_eoc,
  output logic [11:0] adc_data
);
  logic [3:0] cnt_ff;
  logic [1:0] ch_ff;
  // a shoot-through also trips the driver
  assign fault_in = flt_req | (|(gate.top & gate.bot));
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cnt_ff <= 4'hF;
      adc_eoc <= 1'b0;
      adc_data <= 12'hC33;
    end
    else if (adc_start)
    begin
      // old result is junk once a new conversion starts
      cnt_ff <= 4'h0;
      ch_ff <= adc_chan;
      adc_eoc <= 1'b0;
      adc_data <= ~adc_data;
    end
    else if (cnt_ff != 4'hF)
    begin
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff == LAT - 4'h2)
        adc_data <= {ch_ff, 10'h05A};
      if (cnt_ff == LAT)
        adc_eoc <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the motor pwm block
`timescale 1ns/1ps
`include "mpa_cfg.svh"
`default_nettype none
module testbench;
  import mpa_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic flt_req = 1'b0;
  logic [31:0] rdata;
  logic fault_in, adc_start, adc_eoc, irq;
  logic [1:0] adc_chan;
  logic [11:0] adc_data;
  mpa_gate_t gate;
  int failures = 0;
  int checked = 0;
  int hi[6];
  int starts;
  always #10 clk = ~clk;
  mpa_top uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .fault_in(fault_in), .gate(gate), .adc_start(adc_start), .adc_chan(adc_chan),
    .adc_eoc(adc_eoc), .adc_data(adc_data), .irq(irq));
  mpa_drv_model drv (.clk(clk), .rstn(rstn), .gate(gate), .flt_req(flt_req), .fault_in(fault_in),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_eoc(adc_eoc), .adc_data(adc_data));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic watch(input int n);
    hi = '{default: 0};
    starts = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 3; i++)
      begin
        hi[i] += gate.top[i];
        hi[i + 3] += gate.bot[i];
      end
      starts += (adc_start === 1'b1 && adc_chan === 2'h0);
    end
  endtask
  task automatic t_regs;
    logic [31:0] d;
    rd_reg(`MPA_A_CTRL, d);
    chk(d, 32'h10);
    rd_reg(`MPA_A_MOD, d);
    chk(d, 32'h1388);
    rd_reg(`MPA_A_DT, d);
    chk(d, 32'h1F4);
    wr_reg(8'h40, 32'hFFFF);
    rd_reg(8'h40, d);
    chk(d, 32'h0);
    $display("regs test done");
  endtask
  task automatic t_pwm;
    wr_reg(`MPA_A_MOD, 32'h50);
    wr_reg(`MPA_A_DT, 32'h3C);
    wr_reg(`MPA_A_DUTY0, 32'h28);
    wr_reg(`MPA_A_DUTY0 + 8'h04, 32'h14);
    wr_reg(`MPA_A_DUTY0 + 8'h08, 32'h0);
    wr_reg(`MPA_A_MASK, 32'h1);
    wr_reg(`MPA_A_CTRL, 32'h11);
    repeat (200) @(posedge clk);
    watch(80);
    chk(hi[0], 32'h25);
    chk(hi[3], 32'h25);
    chk(hi[1], 32'h11);
    chk(hi[4], 32'h39);
    chk(hi[2], 32'h0);
    chk(hi[5], 32'h50);
    $display("pwm test done");
  endtask
  task automatic t_adc;
    logic [31:0] d;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 500)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({31'h0, irq}, 32'h1);
    rd_reg(`MPA_A_STAT, d);
    chk(d & 32'h1, 32'h1);
    for (int c = 0; c < 4; c++)
    begin
      rd_reg(`MPA_A_RES0 + 8'(4 * c), d);
      chk(d, {20'h0, 2'(c), 10'h05A});
    end
    $display("adc test done");
  endtask
  task automatic t_trig;
    int na;
    int nb;
    int k;
    wr_reg(`MPA_A_TRIG, 32'h5);
    // more than a period, so no start from the old compare point is still in flight
    repeat (100) @(posedge clk);
    #1;
    k = 0;
    while (!(adc_start === 1'b1 && adc_chan === 2'h0) && k < 200)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({31'h0, k < 200}, 32'h1);
    na = 0;
    nb = 0;
    repeat (30)
    begin
      @(posedge clk);
      #1;
      na += gate.top[0];
      nb += gate.top[1];
    end
    chk(nb, 32'h2);
    chk(na, 32'hC);
    $display("trigger test done");
  endtask
  task automatic t_ratio;
    logic [31:0] ctl[5] = '{32'h11, 32'h21, 32'h31, 32'h01, 32'h111};
    logic [31:0] exp[5] = '{32'h6, 32'h3, 32'h2, 32'h6, 32'h0};
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(`MPA_A_CTRL, ctl[i]);
      repeat (240) @(posedge clk);
      watch(480);
      chk(starts, exp[i]);
    end
    $display("ratio test done");
  endtask
  task automatic t_fault;
    logic [31:0] d;
    int k;
    // top a rising pins the count, so the release lands at a known point of the period
    while (gate.top[0] !== 1'b0)
    begin
      @(posedge clk);
      #1;
    end
    while (gate.top[0] !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    flt_req <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk({26'h0, gate}, 32'h0);
    rd_reg(`MPA_A_STAT, d);
    chk(d & 32'h2, 32'h2);
    rd_reg(`MPA_A_STATE, d);
    chk(d, 32'h7);
    @(posedge clk);
    flt_req <= 1'b0;
    k = 0;
    while (gate === 6'h00 && k < 200)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(k, 32'h29);
    watch(160);
    chk({31'h0, hi[0] > 0}, 32'h1);
    $display("fault test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_pwm;
    t_adc;
    t_trig;
    t_ratio;
    t_fault;
    final_report;
  end
  // whole run is near 4350 cycles
  initial
  begin
    #400000;
    failures++;
    final_report;
  end
endmodule
`default_nettype wire
